// ---- hw/usc_core.sv ----
// Mode/status control, transmitter and receiver of an asynchronous serial port.
// Assumes a simple register port (read data one cycle after the strobe) and synchronous pins.
// Notes on behaviour
// - Enable hands pins to the block per pin select; disabled, pins return to port.
// - Stop-in-idle halts the block while the device idle input is high.
// - Infrared coder works on the TX line only in 16x baud mode.
// - RTS mode bit picks simplex (set) or flow control (clear).
// - Pin select: TX/RX, plus RTS, plus RTS/CTS, or plus baud clock.
// - Wake: falling RX edge in sleep raises wake; next rising edge clears bit.
// - Loopback bit routes TX back into RX.
// - Auto-baud measures the next 0x55 character, then clears itself.
// - RX polarity bit sets RX idle level low when set.
// - High-speed bit gives 4 ticks per bit, else 16.
// - Data/parity: 8N, 8E, 8O or 9-bit no parity.
// - Stop select gives two stop bits when set.
// - TX irq mode: on move, on all done, on buffer emptied; 11 reserved.
// - TX polarity sets TX idle level; with coder on the sense is reversed.
// - Break sends start, twelve zeros, stop, then clears itself.
// - Clearing TX enable aborts, flushes buffer, frees TX pin.
// - Read-only TX buffer full and TX all-empty (reset 1) flags.
// - RX irq mode: every char, at 3 chars, at 4 chars.
// - Address detect in 9-bit mode keeps only chars with ninth bit one.
// - Parity and framing flags show the FIFO head character.
// - Overrun set on overflow; software 1-to-0 clear empties receiver.
// - Data-available while buffer not empty; RX idle flag reset to 1.
// - For DMA software sets both irq mode fields to 00.
`timescale 1ns/1ps
`default_nettype none
module usc_core (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	input wire logic dev_idle_in,
	input wire logic dev_sleep_in,
	input wire logic rx_pin_in,
	input wire logic cts_pin_in,
	output logic tx_pin_out,
	output logic tx_pin_oe_out,
	output logic rts_pin_out,
	output logic rts_pin_oe_out,
	output logic bclk_pin_out,
	output logic bclk_pin_oe_out,
	output logic tx_irq_out,
	output logic rx_irq_out,
	output logic wake_irq_out
);
	// ----------------------------------------------------------------
	// Registers and derived controls
	// ----------------------------------------------------------------
	logic [15:0] mode;
	logic [15:0] stat_ctl;
	logic [15:0] baud_div;
	logic overrun;
	logic enabled;
	logic ir_on;
	logic nine_bit;
	logic [4:0] ovs;
	assign enabled = mode[usc_pkg::M_ENABLE] && !(mode[usc_pkg::M_STOP_IDLE] && dev_idle_in);
	assign ir_on = mode[usc_pkg::M_IR] && !mode[usc_pkg::M_HIGH_SPEED];
	assign nine_bit = mode[usc_pkg::M_PAR_HI] && mode[usc_pkg::M_PAR_LO];
	assign ovs = mode[usc_pkg::M_HIGH_SPEED] ? usc_pkg::OVS_HIGH : usc_pkg::OVS_LOW;

	function automatic logic par_of(input logic [8:0] d, input logic odd);
		par_of = ^d[7:0] ^ odd;
	endfunction

	// ----------------------------------------------------------------
	// Baud tick generator
	// ----------------------------------------------------------------
	logic [15:0] brg_cnt;
	logic tick;
	assign tick = enabled && (brg_cnt == 16'h0000);
	always_ff @(posedge clk_in) begin
		if (!rstn_in || !enabled) begin
			brg_cnt <= 16'h0000;
		end else begin
			brg_cnt <= (brg_cnt == 16'h0000) ? baud_div : brg_cnt - 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Buffers
	// ----------------------------------------------------------------
	logic tx_push, tx_pop, rx_push, rx_pop, rx_flush, tx_flush;
	logic [10:0] tx_head, rx_head, rx_word;
	logic [2:0] tx_cnt, rx_cnt;
	assign tx_push = wr_in && addr_in == usc_pkg::ADDR_TXDATA && stat_ctl[usc_pkg::S_TX_EN];
	assign rx_pop = rd_in && addr_in == usc_pkg::ADDR_RXDATA;
	assign tx_flush = !stat_ctl[usc_pkg::S_TX_EN] || !mode[usc_pkg::M_ENABLE];
	assign rx_flush = (wr_in && addr_in == usc_pkg::ADDR_STAT && overrun && !wdata_in[usc_pkg::S_OVERRUN_ERROR]);

	usc_fifo #(.WIDTH(11), .DEPTH(usc_pkg::FIFO_DEPTH)) u_tx_fifo (
		.clk_in(clk_in), .rstn_in(rstn_in), .flush_in(tx_flush), .push_in(tx_push),
		.data_in({2'b00, wdata_in[8:0]}), .pop_in(tx_pop), .head_out(tx_head), .count_out(tx_cnt)
	);
	usc_fifo #(.WIDTH(11), .DEPTH(usc_pkg::FIFO_DEPTH)) u_rx_fifo (
		.clk_in(clk_in), .rstn_in(rstn_in), .flush_in(rx_flush), .push_in(rx_push),
		.data_in(rx_word), .pop_in(rx_pop), .head_out(rx_head), .count_out(rx_cnt)
	);

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	usc_pkg::usc_state_e tx_state;
	logic [4:0] tx_sub;
	logic [3:0] tx_bit;
	logic [3:0] tx_nbits;
	logic [9:0] tx_shift;
	logic tx_line, tx_brk, tx_stop2nd;
	logic cts_ok;
	assign cts_ok = (mode[usc_pkg::M_PIN_HI:usc_pkg::M_PIN_LO] != 2'b10) || !cts_pin_in;
	assign tx_pop = tx_state == usc_pkg::USC_IDLE && tx_cnt != 3'h0 && cts_ok && enabled;

	always_ff @(posedge clk_in) begin
		if (!rstn_in || tx_flush) begin
			tx_state <= usc_pkg::USC_IDLE;
			tx_line <= 1'b1;
			tx_sub <= 5'h00;
			tx_bit <= 4'h0;
			tx_nbits <= 4'h0;
			tx_shift <= 10'h000;
			tx_brk <= 1'b0;
			tx_stop2nd <= 1'b0;
		end else if (tx_pop) begin
			tx_state <= usc_pkg::USC_START;
			tx_line <= 1'b0;
			tx_sub <= 5'h00;
			tx_brk <= stat_ctl[usc_pkg::S_BREAK];
			if (stat_ctl[usc_pkg::S_BREAK]) begin
				tx_shift <= 10'h000;
				tx_nbits <= 4'(usc_pkg::BREAK_ZEROS);
			end else if (nine_bit) begin
				tx_shift <= {1'b0, tx_head[8:0]};
				tx_nbits <= 4'h9;
			end else if (mode[usc_pkg::M_PAR_LO] || mode[usc_pkg::M_PAR_HI]) begin
				tx_shift <= {1'b0, par_of(tx_head[8:0], mode[usc_pkg::M_PAR_HI]), tx_head[7:0]};
				tx_nbits <= 4'h9;
			end else begin
				tx_shift <= {2'b00, tx_head[7:0]};
				tx_nbits <= 4'h8;
			end
		end else if (tick && tx_state != usc_pkg::USC_IDLE) begin
			if (tx_sub == ovs - 5'h01) begin
				tx_sub <= 5'h00;
				unique case (tx_state)
					usc_pkg::USC_START: begin
						tx_state <= usc_pkg::USC_DATA;
						tx_line <= tx_shift[0];
						tx_shift <= tx_shift >> 1;
						tx_bit <= 4'h1;
					end
					usc_pkg::USC_DATA: begin
						if (tx_bit == tx_nbits) begin
							tx_state <= usc_pkg::USC_STOP;
							tx_line <= 1'b1;
							tx_stop2nd <= mode[usc_pkg::M_STOP2];
						end else begin
							tx_line <= tx_shift[0];
							tx_shift <= tx_shift >> 1;
							tx_bit <= tx_bit + 4'h1;
						end
					end
					usc_pkg::USC_STOP: begin
						if (tx_stop2nd) begin
							tx_stop2nd <= 1'b0;
						end else begin
							tx_state <= usc_pkg::USC_IDLE;
							tx_brk <= 1'b0;
						end
					end
					usc_pkg::USC_IDLE: begin
						tx_state <= usc_pkg::USC_IDLE;
					end
				endcase
			end else begin
				tx_sub <= tx_sub + 5'h01;
			end
		end
	end
	logic tx_done;
	assign tx_done = tick && tx_state == usc_pkg::USC_STOP && !tx_stop2nd && tx_sub == ovs - 5'h01;

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	logic rx_raw, rx_line, rx_prev;
	usc_pkg::usc_state_e rx_state;
	logic [4:0] rx_sub;
	logic [3:0] rx_bit, rx_nbits;
	logic [9:0] rx_shift;
	assign rx_raw = mode[usc_pkg::M_LOOPBACK] ? tx_line : (rx_pin_in ^ mode[usc_pkg::M_RX_INV]);
	assign rx_line = rx_raw;
	assign rx_nbits = (mode[usc_pkg::M_PAR_HI] || mode[usc_pkg::M_PAR_LO]) ? 4'h9 : 4'h8;

	logic stop_ok, par_bad, rx_keep, ab_seen;
	always_comb begin
		stop_ok = rx_line;
		par_bad = 1'b0;
		if (!nine_bit && (mode[usc_pkg::M_PAR_HI] || mode[usc_pkg::M_PAR_LO])) begin
			par_bad = par_of({1'b0, rx_shift[8:1]}, mode[usc_pkg::M_PAR_HI]) != rx_shift[9];
		end
		rx_keep = !(mode[usc_pkg::M_AUTOBAUD] || ab_seen) &&
			!(stat_ctl[usc_pkg::S_ADDR_DET] && nine_bit && !rx_shift[9]);
		rx_word = {!stop_ok, par_bad, 1'b0, rx_shift[8:1]};
		// Eight data bits with no parity take one shift fewer, so they sit one place higher.
		if (nine_bit) begin
			rx_word[8:0] = rx_shift[9:1];
		end else if (rx_nbits == 4'h8) begin
			rx_word[8:0] = {1'b0, rx_shift[9:2]};
		end
	end
	logic rx_end;
	assign rx_end = tick && rx_state == usc_pkg::USC_STOP && rx_sub == ovs - 5'h01;
	assign rx_push = rx_end && rx_keep;

	always_ff @(posedge clk_in) begin
		if (!rstn_in || rx_flush || !enabled) begin
			rx_state <= usc_pkg::USC_IDLE;
			rx_sub <= 5'h00;
			rx_bit <= 4'h0;
			rx_shift <= 10'h000;
		end else if (tick) begin
			unique case (rx_state)
				usc_pkg::USC_IDLE: begin
					if (!rx_line) begin
						rx_state <= usc_pkg::USC_START;
						rx_sub <= 5'h00;
					end
				end
				usc_pkg::USC_START: begin
					if (rx_sub == (ovs >> 1) - 5'h01) begin
						rx_sub <= 5'h00;
						rx_state <= rx_line ? usc_pkg::USC_IDLE : usc_pkg::USC_DATA;
						rx_bit <= 4'h0;
					end else begin
						rx_sub <= rx_sub + 5'h01;
					end
				end
				usc_pkg::USC_DATA: begin
					if (rx_sub == ovs - 5'h01) begin
						rx_sub <= 5'h00;
						rx_shift <= {rx_line, rx_shift[9:1]};
						rx_bit <= rx_bit + 4'h1;
						if (rx_bit == rx_nbits - 4'h1) begin
							rx_state <= usc_pkg::USC_STOP;
						end
					end else begin
						rx_sub <= rx_sub + 5'h01;
					end
				end
				usc_pkg::USC_STOP: begin
					if (rx_sub == ovs - 5'h01) begin
						rx_state <= usc_pkg::USC_IDLE;
						rx_sub <= 5'h00;
					end else begin
						rx_sub <= rx_sub + 5'h01;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Auto-baud: count clocks over the eight bit periods of the sync field
	// ----------------------------------------------------------------
	logic ab_run, ab_done;
	logic [3:0] ab_falls;
	logic [19:0] ab_cnt;
	assign ab_done = ab_run && rx_prev && !rx_line && ab_falls == 4'h4;
	always_ff @(posedge clk_in) begin
		if (!rstn_in || !mode[usc_pkg::M_AUTOBAUD]) begin
			ab_run <= 1'b0;
			ab_falls <= 4'h0;
			ab_cnt <= 20'h00000;
		end else if (rx_prev && !rx_line) begin
			ab_run <= 1'b1;
			ab_falls <= ab_falls + 4'h1;
			ab_cnt <= ab_run ? ab_cnt + 20'h00001 : 20'h00000;
		end else if (ab_run) begin
			ab_cnt <= ab_cnt + 20'h00001;
		end
	end

	// Marks the sync character so that it is not stored once the measurement ends inside it.
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ab_seen <= 1'b0;
		end else if (ab_done) begin
			ab_seen <= 1'b1;
		end else if (rx_end) begin
			ab_seen <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= rx_line;
		end
	end

	// ----------------------------------------------------------------
	// Register writes and hardware-cleared bits
	// ----------------------------------------------------------------
	logic wr_mode, wr_stat;
	assign wr_mode = wr_in && addr_in == usc_pkg::ADDR_MODE;
	assign wr_stat = wr_in && addr_in == usc_pkg::ADDR_STAT;
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			mode <= usc_pkg::MODE_RESET;
			baud_div <= usc_pkg::BAUD_RESET;
		end else begin
			if (wr_mode) begin
				mode <= wdata_in & usc_pkg::MODE_WMASK;
			end else begin
				if (mode[usc_pkg::M_WAKE] && rx_line && !rx_prev) begin
					mode[usc_pkg::M_WAKE] <= 1'b0;
				end
				if (ab_done) begin
					mode[usc_pkg::M_AUTOBAUD] <= 1'b0;
				end
			end
			if (ab_done) begin
				baud_div <= 16'((ab_cnt >> (mode[usc_pkg::M_HIGH_SPEED] ? 5 : 7)) - 20'h00001);
			end else if (wr_in && addr_in == usc_pkg::ADDR_BAUD) begin
				baud_div <= wdata_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			stat_ctl <= 16'h0000;
		end else begin
			if (wr_stat) begin
				stat_ctl <= wdata_in & usc_pkg::STAT_WMASK & 16'hFFFD;
			end
			if (tx_done && tx_brk) begin
				stat_ctl[usc_pkg::S_BREAK] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			overrun <= 1'b0;
		end else if (rx_end && rx_keep && rx_cnt == 3'(usc_pkg::FIFO_DEPTH)) begin
			overrun <= 1'b1;
		end else if (wr_stat && !wdata_in[usc_pkg::S_OVERRUN_ERROR]) begin
			overrun <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read port and status
	// ----------------------------------------------------------------
	logic [15:0] stat_view;
	always_comb begin
		stat_view = stat_ctl;
		stat_view[usc_pkg::S_TXBF] = tx_cnt == 3'(usc_pkg::FIFO_DEPTH);
		stat_view[usc_pkg::S_TX_SHIFT_EMPTY] = tx_cnt == 3'h0 && tx_state == usc_pkg::USC_IDLE;
		stat_view[usc_pkg::S_RX_IDLE] = rx_state == usc_pkg::USC_IDLE;
		stat_view[usc_pkg::S_PARITY_ERROR] = rx_cnt != 3'h0 && rx_head[9];
		stat_view[usc_pkg::S_FRAMING_ERROR] = rx_cnt != 3'h0 && rx_head[10];
		stat_view[usc_pkg::S_OVERRUN_ERROR] = overrun;
		stat_view[usc_pkg::S_RXDA] = rx_cnt != 3'h0;
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_in) begin
			unique case (addr_in)
				usc_pkg::ADDR_MODE: rdata_out <= mode;
				usc_pkg::ADDR_STAT: rdata_out <= stat_view;
				usc_pkg::ADDR_RXDATA: rdata_out <= {7'h00, rx_head[8:0]};
				usc_pkg::ADDR_BAUD: rdata_out <= baud_div;
				default: rdata_out <= 16'h0000;
			endcase
		end else begin
			rdata_out <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Pins and interrupts
	// ----------------------------------------------------------------
	logic [1:0] pins;
	logic [1:0] txi;
	logic [1:0] rxi;
	assign pins = mode[usc_pkg::M_PIN_HI:usc_pkg::M_PIN_LO];
	assign txi = {stat_ctl[usc_pkg::S_TXI1], stat_ctl[usc_pkg::S_TXI0]};
	assign rxi = stat_ctl[usc_pkg::S_RXI_HI:usc_pkg::S_RXI_LO];
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			tx_pin_out <= 1'b1;
			tx_pin_oe_out <= 1'b0;
			rts_pin_out <= 1'b1;
			rts_pin_oe_out <= 1'b0;
			bclk_pin_out <= 1'b0;
			bclk_pin_oe_out <= 1'b0;
			tx_irq_out <= 1'b0;
			rx_irq_out <= 1'b0;
			wake_irq_out <= 1'b0;
		end else begin
			// With the coder on, a zero bit becomes a short pulse in the first three ticks of the bit.
			if (ir_on) begin
				tx_pin_out <= (!tx_line && tx_sub < 5'h03) ^ stat_ctl[usc_pkg::S_TX_INV];
			end else begin
				tx_pin_out <= tx_line ^ stat_ctl[usc_pkg::S_TX_INV];
			end
			tx_pin_oe_out <= mode[usc_pkg::M_ENABLE] && stat_ctl[usc_pkg::S_TX_EN];
			rts_pin_out <= mode[usc_pkg::M_RTS_MODE] ? (tx_state == usc_pkg::USC_IDLE)
				: (rx_cnt == 3'(usc_pkg::FIFO_DEPTH));
			rts_pin_oe_out <= mode[usc_pkg::M_ENABLE] && (pins == 2'b01 || pins == 2'b10);
			bclk_pin_out <= tick ? !bclk_pin_out : bclk_pin_out;
			bclk_pin_oe_out <= mode[usc_pkg::M_ENABLE] && pins == 2'b11;
			unique case (txi)
				2'b00: tx_irq_out <= tx_pop;
				2'b01: tx_irq_out <= tx_done && tx_cnt == 3'h0;
				2'b10: tx_irq_out <= tx_pop && tx_cnt == 3'h1;
				2'b11: tx_irq_out <= 1'b0;
			endcase
			unique case (rxi)
				2'b10: rx_irq_out <= rx_push && rx_cnt == 3'h2;
				2'b11: rx_irq_out <= rx_push && rx_cnt == 3'h3;
				default: rx_irq_out <= rx_push;
			endcase
			wake_irq_out <= mode[usc_pkg::M_WAKE] && dev_sleep_in && rx_prev && !rx_line;
		end
	end
endmodule
`default_nettype wire

// ---- hw/usc_fifo.sv ----
// Small synchronous FIFO used for the transmit and receive character buffers.
// Assumes one clock and a synchronous active-low reset; flush empties it at once.
`timescale 1ns/1ps
`default_nettype none
module usc_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic flush_in,
	input wire logic push_in,
	input wire logic [WIDTH-1:0] data_in,
	input wire logic pop_in,
	output logic [WIDTH-1:0] head_out,
	output logic [2:0] count_out
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [1:0] rd_ptr;
	logic [1:0] wr_ptr;
	logic do_push;
	logic do_pop;

	assign do_push = push_in && (count_out != 3'(DEPTH));
	assign do_pop = pop_in && (count_out != 3'h0);
	assign head_out = mem[rd_ptr];

	always_ff @(posedge clk_in) begin
		if (do_push) begin
			mem[wr_ptr] <= data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in || flush_in) begin
			rd_ptr <= 2'h0;
			wr_ptr <= 2'h0;
			count_out <= 3'h0;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + 2'h1;
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + 2'h1;
			end
			count_out <= count_out + 3'(do_push) - 3'(do_pop);
		end
	end
endmodule
`default_nettype wire

// ---- hw/usc_pkg.sv ----
// Constants for the serial mode/status control block.
// Assumes a 16-bit register port with word offsets chosen here.
package usc_pkg;
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h1;
	localparam logic [3:0] ADDR_TXDATA = 4'h2;
	localparam logic [3:0] ADDR_RXDATA = 4'h3;
	localparam logic [3:0] ADDR_BAUD = 4'h4;
	localparam int M_ENABLE = 15;
	localparam int M_STOP_IDLE = 13;
	localparam int M_IR = 12;
	localparam int M_RTS_MODE = 11;
	localparam int M_PIN_HI = 9;
	localparam int M_PIN_LO = 8;
	localparam int M_WAKE = 7;
	localparam int M_LOOPBACK = 6;
	localparam int M_AUTOBAUD = 5;
	localparam int M_RX_INV = 4;
	localparam int M_HIGH_SPEED = 3;
	localparam int M_PAR_HI = 2;
	localparam int M_PAR_LO = 1;
	localparam int M_STOP2 = 0;
	localparam int S_TXI1 = 15;
	localparam int S_TX_INV = 14;
	localparam int S_TXI0 = 13;
	localparam int S_BREAK = 11;
	localparam int S_TX_EN = 10;
	localparam int S_TXBF = 9;
	localparam int S_TX_SHIFT_EMPTY = 8;
	localparam int S_RXI_HI = 7;
	localparam int S_RXI_LO = 6;
	localparam int S_ADDR_DET = 5;
	localparam int S_RX_IDLE = 4;
	localparam int S_PARITY_ERROR = 3;
	localparam int S_FRAMING_ERROR = 2;
	localparam int S_OVERRUN_ERROR = 1;
	localparam int S_RXDA = 0;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] MODE_WMASK = 16'hBBFF;
	localparam logic [15:0] STAT_WMASK = 16'hECE2;
	localparam logic [15:0] BAUD_RESET = 16'h0000;
	localparam logic [7:0] SYNC_CHAR = 8'h55;
	localparam int FIFO_DEPTH = 4;
	localparam int BREAK_ZEROS = 12;
	localparam logic [4:0] OVS_LOW = 5'h10;
	localparam logic [4:0] OVS_HIGH = 5'h04;
	typedef enum logic [1:0] {
		USC_IDLE = 2'b00,
		USC_START = 2'b01,
		USC_DATA = 2'b10,
		USC_STOP = 2'b11
	} usc_state_e;
endpackage

// ---- test/usc_core_assertions.sv ----
// Checker for the serial mode/status control block, bound to its top module.
// Assumes only the top module's ports and the register map of the package.
`timescale 1ns/1ps
`default_nettype none
module usc_core_chk (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] rdata_out,
	input wire logic tx_pin_out,
	input wire logic tx_pin_oe_out,
	input wire logic rts_pin_oe_out,
	input wire logic bclk_pin_oe_out,
	input wire logic tx_irq_out,
	input wire logic rx_irq_out
);
	logic [15:0] mode;
	logic txen;
	logic [1:0] age;
	// ----------------------------------------
	// Register shadows
	// ----------------------------------------
	// Pin ownership is judged only once the control writes have settled.
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			mode <= usc_pkg::MODE_RESET;
			txen <= 1'b0;
		end else if (wr_in && addr_in == usc_pkg::ADDR_MODE) begin
			mode <= wdata_in & usc_pkg::MODE_WMASK;
		end else if (wr_in && addr_in == usc_pkg::ADDR_STAT) begin
			txen <= wdata_in[usc_pkg::S_TX_EN];
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rstn_in || (wr_in && addr_in <= usc_pkg::ADDR_STAT)) begin
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	AST_TX_OE: assert property (age == 2'h3 && !(mode[15] && txen) |-> !tx_pin_oe_out)
		else $error("tx pin driven while not owned");
	AST_RTS_OE: assert property (age == 2'h3 |-> rts_pin_oe_out == (mode[15] && ^mode[9:8]))
		else $error("rts pin ownership wrong");
	AST_BCLK_OE: assert property (age == 2'h3 |-> bclk_pin_oe_out == (mode[15] && &mode[9:8]))
		else $error("baud clock pin ownership wrong");
	AST_UNMAPPED: assert property ($past(rd_in) && $past(addr_in) > usc_pkg::ADDR_BAUD |-> rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	AST_RDATA_QUIET: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
		else $error("read data outside its cycle");
	AST_IRQ_PULSE: assert property (tx_irq_out |=> !tx_irq_out)
		else $error("tx interrupt longer than one cycle");
	AST_RX_IRQ_EN: assert property (rx_irq_out |-> mode[15])
		else $error("rx interrupt while disabled");
	AST_TX_IDLE: assert property ($rose(rstn_in) |-> (tx_pin_out && !tx_pin_oe_out && !bclk_pin_oe_out) [*3])
		else $error("pins not idle after reset");
	AST_TX_START: assert property ($fell(tx_pin_out) && tx_pin_oe_out && !mode[12]
		|=> (!tx_pin_out || !tx_pin_oe_out) [*3])
		else $error("low bit shorter than four clocks");
endmodule
bind usc_core usc_core_chk chk (
	.clk_in(clk_in),
	.rstn_in(rstn_in),
	.addr_in(addr_in),
	.wdata_in(wdata_in),
	.wr_in(wr_in),
	.rd_in(rd_in),
	.rdata_out(rdata_out),
	.tx_pin_out(tx_pin_out),
	.tx_pin_oe_out(tx_pin_oe_out),
	.rts_pin_oe_out(rts_pin_oe_out),
	.bclk_pin_oe_out(bclk_pin_oe_out),
	.tx_irq_out(tx_irq_out),
	.rx_irq_out(rx_irq_out)
);
`default_nettype wire

// ---- test/usc_core_tb_top.sv ----
// Self-checking bench for the serial mode/status control block.
// Assumes the register map of the package and a remote device model.
`timescale 1ns/1ps
`default_nettype none
module usc_core_tb_top;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [15:0] wdata_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [15:0] rdata_out;
	logic rx_line;
	logic tx_pin_out, tx_pin_oe_out, rts_pin_out, rts_pin_oe_out, bclk_pin_out, bclk_pin_oe_out;
	logic tx_irq_out, rx_irq_out, wake_irq_out;
	int errors = 0;
	int num_checks = 0;
	int irqs = 0;
	logic [15:0] lfsr = 16'hCF43;
	logic [15:0] got;
	logic [15:0] rd;
	logic [7:0] q[$];
	// An undriven TX pin floats to the pulled-up idle level.
	wire logic tx_wire = tx_pin_oe_out ? tx_pin_out : 1'b1;
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in) if (rx_irq_out === 1'b1) irqs <= irqs + 1;
	usc_core uut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .dev_idle_in(1'b0), .dev_sleep_in(1'b0),
		.rx_pin_in(rx_line), .cts_pin_in(1'b0), .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out),
		.rts_pin_out(rts_pin_out), .rts_pin_oe_out(rts_pin_oe_out), .bclk_pin_out(bclk_pin_out),
		.bclk_pin_oe_out(bclk_pin_oe_out), .tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out),
		.wake_irq_out(wake_irq_out));
	usc_remote rem (.clk_in(clk_in), .line_in(tx_wire), .line_out(rx_line));
	// ----------------------------------------
	// Helpers and reference model
	// ----------------------------------------
	function automatic logic [15:0] nxt(input logic [15:0] l);
		return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
	endfunction
	// Builds the expected line bits of one character and returns their count.
	function automatic int mk(input logic [8:0] d, input int dps, input int st, output logic [15:0] f);
		int n;
		n = (dps == 3) ? 9 : 8;
		f = 16'h0000;
		for (int i = 0; i < n; i++) f[i + 1] = d[i];
		if (dps == 1 || dps == 2) begin
			f[n + 1] = (^d[7:0]) ^ (dps == 2);
			n++;
		end
		f[n + 1] = 1'b1;
		f[n + 2] = (st == 1);
		return n + 2 + st;
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask
	// Sends one 8-bit even-parity character, optionally with bad parity or a low stop bit.
	task automatic sendc(input logic bp, input logic bs);
		lfsr = nxt(lfsr);
		q.push_back(lfsr[7:0]);
		rem.send({5'h00, ~bs, (^lfsr[7:0]) ^ bp, lfsr[7:0], 1'b0}, 11, 16);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		end_sim();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [15:0] f;
		int n;
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		rdr(usc_pkg::ADDR_MODE, rd);
		check("mode reset", rd, usc_pkg::MODE_RESET);
		rdr(usc_pkg::ADDR_STAT, rd);
		check("status reset", rd, 16'h0110);
		rdr(4'hF, rd);
		for (int p = 0; p < 4; p++) begin
			wr(usc_pkg::ADDR_MODE, {6'b100000, p[1:0], 8'h00});
			wr(usc_pkg::ADDR_STAT, 16'h0400);
			repeat (4) @(posedge clk_in);
			check("pin oe", {13'h0, tx_pin_oe_out, rts_pin_oe_out, bclk_pin_oe_out},
				{13'h0, 1'b1, p == 1 || p == 2, p == 3});
		end
		wr(usc_pkg::ADDR_MODE, 16'h0000);
		repeat (4) @(posedge clk_in);
		check("pin oe off", {13'h0, tx_pin_oe_out, rts_pin_oe_out, bclk_pin_oe_out}, 16'h0000);
		for (int k = 0; k < 8; k++) begin
			lfsr = nxt(lfsr);
			wr(usc_pkg::ADDR_MODE, {8'h80, 4'h0, 1'b1, k[2:1], k[0]});
			n = mk(lfsr[8:0], k[2:1], k[0], f);
			fork
				rem.receive(got, n, 4);
				wr(usc_pkg::ADDR_TXDATA, {7'h00, lfsr[8:0]});
			join
			check("tx frame", got, f);
			repeat (8) @(posedge clk_in);
		end
		for (int i = 0; i < 5; i++) wr(usc_pkg::ADDR_TXDATA, 16'h00A5);
		rdr(usc_pkg::ADDR_STAT, rd);
		check("tx full", rd & 16'h0300, 16'h0200);
		wr(usc_pkg::ADDR_STAT, 16'h0000);
		rdr(usc_pkg::ADDR_STAT, rd);
		check("tx abort", {rd[15:1] & 15'h0180, tx_pin_oe_out}, 16'h0100);
		wr(usc_pkg::ADDR_STAT, 16'h0C00);
		fork
			rem.receive(got, 14, 4);
			wr(usc_pkg::ADDR_TXDATA, 16'h0055);
		join
		check("break frame", got, 16'h2000);
		repeat (16) @(posedge clk_in);
		rdr(usc_pkg::ADDR_STAT, rd);
		check("break done", rd & 16'h0900, 16'h0100);
		wr(usc_pkg::ADDR_MODE, 16'h8002);
		wr(usc_pkg::ADDR_STAT, 16'h00C0);
		irqs = 0;
		sendc(1'b1, 1'b0);
		sendc(1'b0, 1'b1);
		sendc(1'b0, 1'b0);
		sendc(1'b0, 1'b0);
		repeat (16) @(posedge clk_in);
		check("rx irq count", irqs[15:0], 16'h0001);
		rdr(usc_pkg::ADDR_STAT, rd);
		check("rx head parity", rd & 16'h001F, 16'h0019);
		rdr(usc_pkg::ADDR_RXDATA, rd);
		check("rx data", {8'h00, rd[7:0]}, {8'h00, q.pop_front()});
		rdr(usc_pkg::ADDR_STAT, rd);
		check("rx head framing", rd & 16'h001F, 16'h0015);
		rdr(usc_pkg::ADDR_RXDATA, rd);
		check("rx data", {8'h00, rd[7:0]}, {8'h00, q.pop_front()});
		repeat (3) sendc(1'b0, 1'b0);
		repeat (16) @(posedge clk_in);
		rdr(usc_pkg::ADDR_STAT, rd);
		check("overrun", rd & 16'h0003, 16'h0003);
		check("rts full", {15'h0, rts_pin_out}, 16'h0001);
		wr(usc_pkg::ADDR_STAT, 16'h00C0);
		rdr(usc_pkg::ADDR_STAT, rd);
		check("overrun clear", rd & 16'h0003, 16'h0000);
		wr(usc_pkg::ADDR_MODE, 16'h8048);
		wr(usc_pkg::ADDR_STAT, 16'h0400);
		lfsr = nxt(lfsr);
		wr(usc_pkg::ADDR_TXDATA, {8'h00, lfsr[7:0]});
		repeat (60) @(posedge clk_in);
		rdr(usc_pkg::ADDR_RXDATA, rd);
		check("loopback 8N", rd, {8'h00, lfsr[7:0]});
		wr(usc_pkg::ADDR_MODE, 16'h9000);
		repeat (4) @(posedge clk_in);
		check("ir idle", {15'h0, tx_pin_out}, 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire

// ---- test/usc_remote.sv ----
// Behavioural remote serial device on the TX/RX pair of the block.
// Assumes the bench calls its tasks and gives the bit length in clocks.
`timescale 1ns/1ps
`default_nettype none
module usc_remote (
	input wire logic clk_in,
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	// Sends len bits first bit first, then one idle bit at the high level.
	task automatic send(input logic [15:0] frame, input int len, input int bc);
		for (int i = 0; i <= len; i++) begin
			@(posedge clk_in);
			line_out <= (i == len) ? 1'b1 : frame[i];
			repeat (bc - 1) @(posedge clk_in);
		end
	endtask
	// Waits for a start edge, then samples len bits at their centres.
	task automatic receive(output logic [15:0] got, input int len, input int bc);
		int k;
		got = 16'h0000;
		k = 0;
		while (line_in !== 1'b0 && k < 5000) begin
			@(negedge clk_in);
			k++;
		end
		repeat (bc / 2) @(negedge clk_in);
		for (int i = 0; i < len; i++) begin
			got[i] = line_in;
			repeat (bc) @(negedge clk_in);
		end
	endtask
endmodule
`default_nettype wire
